//--- verilog/cgl_pkg.sv
// Shared constants and operation codes for the compare greater/less unit
package cgl_pkg;

    // Operand and result geometry
    localparam int DATA_W = 32;
    localparam int COND_W = 4;
    localparam int HALF_LANES = 2;
    localparam int HALF_W = 16;
    localparam int BYTE_LANES = 4;
    localparam int BYTE_W = 8;
    localparam int HALF_GROUP_W = 2;

    // Cycles between a condition write and a conditional branch reading it
    localparam int COND_BRANCH_LAT = 2;
    localparam int COND_CNT_W = 2;
    localparam logic [COND_CNT_W-1:0] COND_CNT_LOAD = COND_CNT_W'(COND_BRANCH_LAT - 1);
    localparam logic [COND_CNT_W-1:0] COND_CNT_IDLE = 2'h0;

    // Single precision field layout
    localparam int FP_SIGN_BIT = 31;
    localparam int FP_EXP_MSB = 30;
    localparam int FP_EXP_LSB = 23;
    localparam int FP_MANT_MSB = 22;
    localparam logic [7:0] FP_EXP_ALL_ONES = 8'hFF;
    localparam logic [7:0] FP_EXP_ZERO = 8'h00;
    localparam logic [22:0] FP_MANT_ZERO = 23'h000000;

    // Reset and constant values
    localparam logic [DATA_W-1:0] DATA_RESET = 32'h00000000;
    localparam logic [DATA_W-1:0] SCALAR_TRUE = 32'h00000001;
    localparam logic [COND_W-1:0] COND_RESET = 4'h0;
    localparam logic [COND_W-1:0] COND_SCALAR_TRUE = 4'h1;
    localparam logic [BYTE_W-1:0] BYTE_TRUE = 8'h01;
    localparam logic [HALF_W-1:0] HALF_TRUE = 16'h0001;

    // Operation codes delivered by the issue pipeline
    typedef enum logic [2:0] {
        CGL_OP_NONE = 3'h0,
        CGL_OP_GT_S = 3'h1,
        CGL_OP_LE_S = 3'h2,
        CGL_OP_GT_U = 3'h3,
        CGL_OP_GTU_PB = 3'h4,
        CGL_OP_GT_PH = 3'h5,
        CGL_OP_LE_U = 3'h6,
        CGL_OP_GT_F = 3'h7
    } cgl_op_t;

endpackage : cgl_pkg

//--- verilog/cgl_fp_greater.sv
// Single precision greater-than comparator, combinational
`timescale 1ns/1ps
`default_nettype none

module cgl_fp_greater (
    input wire logic [31:0] opndA,
    input wire logic [31:0] opndB,
    output logic greater
);

    logic [7:0] expA;
    logic [7:0] expB;
    logic [22:0] mantA;
    logic [22:0] mantB;
    logic nanA;
    logic nanB;
    logic zeroA;
    logic zeroB;
    logic negA;
    logic negB;
    logic [30:0] magA;
    logic [30:0] magB;

    always_comb
    begin
        expA = opndA[cgl_pkg::FP_EXP_MSB:cgl_pkg::FP_EXP_LSB];
        expB = opndB[cgl_pkg::FP_EXP_MSB:cgl_pkg::FP_EXP_LSB];
        mantA = opndA[cgl_pkg::FP_MANT_MSB:0];
        mantB = opndB[cgl_pkg::FP_MANT_MSB:0];
        nanA = (expA == cgl_pkg::FP_EXP_ALL_ONES) && (mantA != cgl_pkg::FP_MANT_ZERO);
        nanB = (expB == cgl_pkg::FP_EXP_ALL_ONES) && (mantB != cgl_pkg::FP_MANT_ZERO);
        // Denormals flush to zero, so both signs of zero compare equal
        zeroA = (expA == cgl_pkg::FP_EXP_ZERO);
        zeroB = (expB == cgl_pkg::FP_EXP_ZERO);
        negA = opndA[cgl_pkg::FP_SIGN_BIT] && !zeroA;
        negB = opndB[cgl_pkg::FP_SIGN_BIT] && !zeroB;
        magA = zeroA ? 31'h00000000 : opndA[30:0];
        magB = zeroB ? 31'h00000000 : opndB[30:0];
        if (nanA || nanB)
        begin
            greater = 1'b0;
        end
        else if (negA != negB)
        begin
            greater = negB;
        end
        else if (negA)
        begin
            greater = magA < magB;
        end
        else
        begin
            greater = magA > magB;
        end
    end

endmodule : cgl_fp_greater

`default_nettype wire

//--- verilog/cgl_compare_unit.sv
// Greater-than and less-or-equal compare unit: scalar, packed and float forms
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Packed half greater to condition: signed 16-bit lanes, each outcome fills two bits.
// - Packed half greater to general register: lane outcome in its own 16-bit field.
// - Float greater: single precision operands, true when first is greater, either destination.
// - Unsigned greater: zero-extend register and immediate to 32 bits, then compare.
// - Packed byte unsigned greater to condition: bit j from lane j.
// - Packed byte unsigned greater to general register: outcome per 8-bit field.
// - Signed greater with immediate: sign-extend both to 32 bits, then compare.
// - Signed less-or-equal, register or immediate second operand, either destination.
// - Unsigned less-or-equal, register or immediate second operand, either destination.
// - Other readers see a fresh condition at once; general results carry no constraint.
// - Every compare accepted anywhere, never raises an exception.
module cgl_compare_unit #(
    parameter int GPR_IDX_W = 6,
    parameter int COND_IDX_W = 3,
    parameter int NUM_COND = 8,
    parameter int IMM_W = 32
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic opValid,
    input wire cgl_pkg::cgl_op_t opCode,
    input wire logic [cgl_pkg::DATA_W-1:0] firstSourceReg,
    input wire logic [cgl_pkg::DATA_W-1:0] secondSourceReg,
    input wire logic [IMM_W-1:0] immediateOperand,
    input wire logic useImmediate,
    input wire logic destIsCondition,
    input wire logic [GPR_IDX_W-1:0] generalDestIdx,
    input wire logic [COND_IDX_W-1:0] conditionDestIdx,
    output logic gprWriteEn,
    output logic [GPR_IDX_W-1:0] gprWriteIdx,
    output logic [cgl_pkg::DATA_W-1:0] gprWriteData,
    output logic condWriteEn,
    output logic [COND_IDX_W-1:0] condWriteIdx,
    output logic [cgl_pkg::COND_W-1:0] condWriteData,
    output logic [NUM_COND-1:0] condBranchReady
);

    typedef struct packed {
        logic gprWe;
        logic [GPR_IDX_W-1:0] gprIdx;
        logic [cgl_pkg::DATA_W-1:0] gprData;
        logic condWe;
        logic [COND_IDX_W-1:0] condIdx;
        logic [cgl_pkg::COND_W-1:0] condData;
        logic [NUM_COND-1:0] condReady;
        logic [NUM_COND-1:0][cgl_pkg::COND_CNT_W-1:0] condCnt;
    } cgl_state_t;

    cgl_state_t state_q;
    cgl_state_t state_d;

    logic [cgl_pkg::DATA_W-1:0] opndA;
    logic [cgl_pkg::DATA_W-1:0] opndB;
    logic fpGreater;
    logic scalarTrue;
    logic [cgl_pkg::COND_W-1:0] condResult;
    logic [cgl_pkg::DATA_W-1:0] gprResult;
    logic [cgl_pkg::HALF_LANES-1:0] halfOutcome;
    logic [cgl_pkg::BYTE_LANES-1:0] byteOutcome;

    // Immediate widened by the signedness of the operation
    function automatic logic [cgl_pkg::DATA_W-1:0] extendImm(
        input logic [IMM_W-1:0] imm,
        input logic isSigned
    );
        logic [cgl_pkg::DATA_W-1:0] ext;
        if (isSigned)
        begin
            ext = cgl_pkg::DATA_W'($signed(imm));
        end
        else
        begin
            ext = cgl_pkg::DATA_W'(imm);
        end
        return ext;
    endfunction : extendImm

    function automatic logic signedGreater(
        input logic [cgl_pkg::DATA_W-1:0] a,
        input logic [cgl_pkg::DATA_W-1:0] b
    );
        return $signed(a) > $signed(b);
    endfunction : signedGreater

    function automatic logic [cgl_pkg::HALF_LANES-1:0] halfLanesGreater(
        input logic [cgl_pkg::DATA_W-1:0] a,
        input logic [cgl_pkg::DATA_W-1:0] b
    );
        logic [cgl_pkg::HALF_LANES-1:0] res;
        res = '0;
        for (int j = 0; j < cgl_pkg::HALF_LANES; j++)
        begin
            res[j] = $signed(a[j*cgl_pkg::HALF_W +: cgl_pkg::HALF_W]) >
                     $signed(b[j*cgl_pkg::HALF_W +: cgl_pkg::HALF_W]);
        end
        return res;
    endfunction : halfLanesGreater

    function automatic logic [cgl_pkg::BYTE_LANES-1:0] byteLanesGreater(
        input logic [cgl_pkg::DATA_W-1:0] a,
        input logic [cgl_pkg::DATA_W-1:0] b
    );
        logic [cgl_pkg::BYTE_LANES-1:0] res;
        res = '0;
        for (int j = 0; j < cgl_pkg::BYTE_LANES; j++)
        begin
            res[j] = a[j*cgl_pkg::BYTE_W +: cgl_pkg::BYTE_W] > b[j*cgl_pkg::BYTE_W +: cgl_pkg::BYTE_W];
        end
        return res;
    endfunction : byteLanesGreater

    function automatic logic unsignedGreater(
        input logic [cgl_pkg::DATA_W-1:0] a,
        input logic [cgl_pkg::DATA_W-1:0] b
    );
        return a > b;
    endfunction : unsignedGreater

    // The empty code occupies a slot without writing anything
    function automatic logic isTaken(
        input logic valid,
        input cgl_pkg::cgl_op_t code
    );
        return valid && (code != cgl_pkg::CGL_OP_NONE);
    endfunction : isTaken

    // Packed register operations only ever use the second register
    always_comb
    begin
        opndA = firstSourceReg;
        unique case (opCode)
            cgl_pkg::CGL_OP_GT_S,
            cgl_pkg::CGL_OP_LE_S:
            begin
                if (useImmediate)
                begin
                    opndB = extendImm(immediateOperand, 1'b1);
                end
                else
                begin
                    opndB = secondSourceReg;
                end
            end
            cgl_pkg::CGL_OP_GT_U,
            cgl_pkg::CGL_OP_LE_U:
            begin
                if (useImmediate)
                begin
                    opndB = extendImm(immediateOperand, 1'b0);
                end
                else
                begin
                    opndB = secondSourceReg;
                end
            end
            default:
            begin
                opndB = secondSourceReg;
            end
        endcase
    end

    cgl_fp_greater u_fp_greater (
        .opndA(opndA),
        .opndB(opndB),
        .greater(fpGreater)
    );

    always_comb
    begin
        halfOutcome = halfLanesGreater(opndA, opndB);
        byteOutcome = byteLanesGreater(opndA, opndB);
        scalarTrue = 1'b0;
        condResult = cgl_pkg::COND_RESET;
        gprResult = cgl_pkg::DATA_RESET;
        unique case (opCode)
            cgl_pkg::CGL_OP_GT_S:
            begin
                scalarTrue = signedGreater(opndA, opndB);
            end
            cgl_pkg::CGL_OP_LE_S:
            begin
                scalarTrue = !signedGreater(opndA, opndB);
            end
            cgl_pkg::CGL_OP_GT_U:
            begin
                scalarTrue = unsignedGreater(opndA, opndB);
            end
            cgl_pkg::CGL_OP_LE_U:
            begin
                scalarTrue = !unsignedGreater(opndA, opndB);
            end
            cgl_pkg::CGL_OP_GT_F:
            begin
                scalarTrue = fpGreater;
            end
            default:
            begin
                scalarTrue = 1'b0;
            end
        endcase
        if (opCode == cgl_pkg::CGL_OP_GT_PH)
        begin
            for (int j = 0; j < cgl_pkg::HALF_LANES; j++)
            begin
                condResult[j*cgl_pkg::HALF_GROUP_W +: cgl_pkg::HALF_GROUP_W] =
                    {cgl_pkg::HALF_GROUP_W{halfOutcome[j]}};
                gprResult[j*cgl_pkg::HALF_W +: cgl_pkg::HALF_W] =
                    halfOutcome[j] ? cgl_pkg::HALF_TRUE : '0;
            end
        end
        else if (opCode == cgl_pkg::CGL_OP_GTU_PB)
        begin
            condResult = byteOutcome;
            for (int j = 0; j < cgl_pkg::BYTE_LANES; j++)
            begin
                gprResult[j*cgl_pkg::BYTE_W +: cgl_pkg::BYTE_W] =
                    byteOutcome[j] ? cgl_pkg::BYTE_TRUE : '0;
            end
        end
        else
        begin
            condResult = scalarTrue ? cgl_pkg::COND_SCALAR_TRUE : cgl_pkg::COND_RESET;
            gprResult = scalarTrue ? cgl_pkg::SCALAR_TRUE : cgl_pkg::DATA_RESET;
        end
    end

    // No illegal-code trap exists: every code is a compare or a no-op
    always_comb
    begin
        state_d = state_q;
        state_d.gprWe = 1'b0;
        state_d.condWe = 1'b0;
        if (isTaken(opValid, opCode))
        begin
            if (destIsCondition)
            begin
                state_d.condWe = 1'b1;
                state_d.condIdx = conditionDestIdx;
                state_d.condData = condResult;
            end
            else
            begin
                state_d.gprWe = 1'b1;
                state_d.gprIdx = generalDestIdx;
                state_d.gprData = gprResult;
            end
        end
        // Readiness for conditional branches lags the write by the branch latency
        for (int i = 0; i < NUM_COND; i++)
        begin
            if (isTaken(opValid, opCode) && destIsCondition &&
                (conditionDestIdx == COND_IDX_W'(i)))
            begin
                state_d.condCnt[i] = cgl_pkg::COND_CNT_LOAD;
                state_d.condReady[i] = 1'b0;
            end
            else if (state_q.condCnt[i] != cgl_pkg::COND_CNT_IDLE)
            begin
                state_d.condCnt[i] = state_q.condCnt[i] - 1'b1;
                state_d.condReady[i] = (state_q.condCnt[i] == 2'h1);
            end
            else
            begin
                state_d.condReady[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            state_q.gprWe <= 1'b0;
            state_q.gprIdx <= '0;
            state_q.gprData <= cgl_pkg::DATA_RESET;
            state_q.condWe <= 1'b0;
            state_q.condIdx <= '0;
            state_q.condData <= cgl_pkg::COND_RESET;
            state_q.condReady <= '1;
            state_q.condCnt <= '0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign gprWriteEn = state_q.gprWe;
    assign gprWriteIdx = state_q.gprIdx;
    assign gprWriteData = state_q.gprData;
    assign condWriteEn = state_q.condWe;
    assign condWriteIdx = state_q.condIdx;
    assign condWriteData = state_q.condData;
    assign condBranchReady = state_q.condReady;

endmodule : cgl_compare_unit

`default_nettype wire

//--- verif/cgl_compare_unit_properties.sv
// Port-level checks of the compare unit
`timescale 1ns/1ps
`default_nettype none
module cgl_compare_unit_properties #(
    parameter int GPR_IDX_W = 6,
    parameter int COND_IDX_W = 3,
    parameter int NUM_COND = 8,
    parameter int IMM_W = 32
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic opValid,
    input wire cgl_pkg::cgl_op_t opCode,
    input wire logic [31:0] firstSourceReg,
    input wire logic [31:0] secondSourceReg,
    input wire logic [IMM_W-1:0] immediateOperand,
    input wire logic useImmediate,
    input wire logic destIsCondition,
    input wire logic [GPR_IDX_W-1:0] generalDestIdx,
    input wire logic [COND_IDX_W-1:0] conditionDestIdx,
    input wire logic gprWriteEn,
    input wire logic [GPR_IDX_W-1:0] gprWriteIdx,
    input wire logic [31:0] gprWriteData,
    input wire logic condWriteEn,
    input wire logic [COND_IDX_W-1:0] condWriteIdx,
    input wire logic [3:0] condWriteData,
    input wire logic [NUM_COND-1:0] condBranchReady
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    sequence takenOp;
        opValid && opCode != cgl_pkg::CGL_OP_NONE;
    endsequence
    sequence takenCond;
        takenOp ##0 destIsCondition;
    endsequence
    cond_pulse_a: assert property (takenCond |=>
        condWriteEn && !gprWriteEn && condWriteIdx == $past(conditionDestIdx)) else $error("no condition write");
    gpr_pulse_a: assert property ((takenOp ##0 !destIsCondition) |=>
        gprWriteEn && !condWriteEn && gprWriteIdx == $past(generalDestIdx)) else $error("no general write");
    idle_quiet_a: assert property (!(opValid && opCode != cgl_pkg::CGL_OP_NONE) |=>
        !gprWriteEn && !condWriteEn) else $error("write without operation");
    ready_drop_a: assert property (condWriteEn |-> !condBranchReady[condWriteIdx])
        else $error("branch ready too early");
    ready_back_a: assert property (condWriteEn |=> condBranchReady[$past(condWriteIdx)]
        || (condWriteEn && condWriteIdx == $past(condWriteIdx))) else $error("branch ready late");
    scalar_bits_a: assert property ((takenOp ##0 (!destIsCondition && opCode inside {cgl_pkg::CGL_OP_GT_S,
        cgl_pkg::CGL_OP_LE_S, cgl_pkg::CGL_OP_GT_U, cgl_pkg::CGL_OP_LE_U, cgl_pkg::CGL_OP_GT_F}))
        |=> gprWriteData[31:1] == 31'h0) else $error("scalar upper bits set");
    unsigned_gt_a: assert property ((takenOp ##0 (opCode == cgl_pkg::CGL_OP_GT_U && useImmediate
        && !destIsCondition)) |=> gprWriteData[0] == ($past(firstSourceReg) > 32'($past(immediateOperand))))
        else $error("unsigned greater wrong");
    signed_le_a: assert property ((takenCond ##0 (opCode == cgl_pkg::CGL_OP_LE_S && !useImmediate)) |=>
        condWriteData == {3'h0, $signed($past(firstSourceReg)) <= $signed($past(secondSourceReg))})
        else $error("signed less-equal wrong");
    byte_cond_a: assert property ((takenCond ##0 (opCode == cgl_pkg::CGL_OP_GTU_PB)) |=>
        condWriteData[3] == ($past(firstSourceReg[31:24]) > $past(secondSourceReg[31:24])))
        else $error("byte lane outcome wrong");
endmodule : cgl_compare_unit_properties
bind cgl_compare_unit cgl_compare_unit_properties #(.GPR_IDX_W(GPR_IDX_W), .COND_IDX_W(COND_IDX_W),
    .NUM_COND(NUM_COND), .IMM_W(IMM_W)) i_props (.clk_sys(clk_sys), .reset_n(reset_n), .opValid(opValid),
    .opCode(opCode), .firstSourceReg(firstSourceReg), .secondSourceReg(secondSourceReg),
    .immediateOperand(immediateOperand), .useImmediate(useImmediate), .destIsCondition(destIsCondition),
    .generalDestIdx(generalDestIdx), .conditionDestIdx(conditionDestIdx), .gprWriteEn(gprWriteEn),
    .gprWriteIdx(gprWriteIdx), .gprWriteData(gprWriteData), .condWriteEn(condWriteEn),
    .condWriteIdx(condWriteIdx), .condWriteData(condWriteData), .condBranchReady(condBranchReady));
`default_nettype wire

//--- verif/cgl_branch_model.sv
// Conditional branch unit model reading condition registers
`timescale 1ns/1ps
`default_nettype none
module cgl_branch_model (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic condWriteEn,
    input wire logic [2:0] condWriteIdx,
    input wire logic [3:0] condWriteData,
    input wire logic [7:0] condBranchReady,
    input wire logic brReq,
    input wire logic [2:0] brIdx,
    output logic brDone,
    output logic brTrue
);
    logic [3:0] condFile [8];
    always_ff @(posedge clk_sys)
    begin
        if (condWriteEn)
            condFile[condWriteIdx] <= condWriteData;
        // Stall until the fresh condition may be read by a branch
        brDone <= reset_n && brReq && !brDone && condBranchReady[brIdx];
        brTrue <= condFile[brIdx][0];
    end
endmodule : cgl_branch_model
`default_nettype wire

//--- verif/compare_greater_less_unit_tb.sv
// Self-checking bench of the compare unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; \
    $display("[FAIL] %0t got %h expected %h", $time, (g), (e)); end end
module compare_greater_less_unit_tb;
    logic clk_sys = 0, reset_n = 0, opValid = 0, useImmediate = 0, destIsCondition = 0, brReq = 0;
    cgl_pkg::cgl_op_t opCode = cgl_pkg::CGL_OP_NONE;
    logic [31:0] firstSourceReg = '0, secondSourceReg = '0, immediateOperand = '0, gprWriteData;
    logic [5:0] generalDestIdx = '0, gprWriteIdx;
    logic [2:0] conditionDestIdx = '0, condWriteIdx, brIdx = '0;
    logic [3:0] condWriteData;
    logic [7:0] condBranchReady;
    logic gprWriteEn, condWriteEn, brDone, brTrue;
    int failures = 0, checked = 0, cycles = 0;
    cgl_compare_unit i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .opValid(opValid), .opCode(opCode),
        .firstSourceReg(firstSourceReg), .secondSourceReg(secondSourceReg), .immediateOperand(immediateOperand),
        .useImmediate(useImmediate), .destIsCondition(destIsCondition), .generalDestIdx(generalDestIdx),
        .conditionDestIdx(conditionDestIdx), .gprWriteEn(gprWriteEn), .gprWriteIdx(gprWriteIdx),
        .gprWriteData(gprWriteData), .condWriteEn(condWriteEn), .condWriteIdx(condWriteIdx),
        .condWriteData(condWriteData), .condBranchReady(condBranchReady));
    cgl_branch_model i_branch (.clk_sys(clk_sys), .reset_n(reset_n), .condWriteEn(condWriteEn),
        .condWriteIdx(condWriteIdx), .condWriteData(condWriteData), .condBranchReady(condBranchReady),
        .brReq(brReq), .brIdx(brIdx), .brDone(brDone), .brTrue(brTrue));
    initial forever #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            failures++;
            tally_and_finish();
        end
    end
    // Flush-to-zero ordering key; NaN handled by caller
    function automatic int fkey(logic [31:0] v);
        if (v[30:23] == 8'h00)
            return 0;
        return v[31] ? -int'(v[30:0]) : int'(v[30:0]);
    endfunction : fkey
    function automatic logic [35:0] expect_of(cgl_pkg::cgl_op_t op, logic [31:0] a, logic [31:0] b);
        logic r;
        logic [35:0] e;
        e = '0;
        case (op)
            cgl_pkg::CGL_OP_GT_PH: for (int j = 0; j < 2; j++)
            begin
                r = $signed(a[16*j+:16]) > $signed(b[16*j+:16]);
                e[32+2*j+:2] = {2{r}};
                e[16*j] = r;
            end
            cgl_pkg::CGL_OP_GTU_PB: for (int j = 0; j < 4; j++)
            begin
                r = a[8*j+:8] > b[8*j+:8];
                e[32+j] = r;
                e[8*j] = r;
            end
            default:
            begin
                case (op)
                    cgl_pkg::CGL_OP_GT_S: r = $signed(a) > $signed(b);
                    cgl_pkg::CGL_OP_LE_S: r = $signed(a) <= $signed(b);
                    cgl_pkg::CGL_OP_GT_U: r = a > b;
                    cgl_pkg::CGL_OP_LE_U: r = a <= b;
                    default: r = !((&a[30:23]) && a[22:0] != 0) && !((&b[30:23]) && b[22:0] != 0)
                        && fkey(a) > fkey(b);
                endcase
                e = {3'h0, r, 31'h0, r};
            end
        endcase
        return e;
    endfunction : expect_of
    // Drives one operation, checks the answer in the cycle after it is taken
    task automatic issue(cgl_pkg::cgl_op_t op, logic [31:0] a, logic [31:0] b, logic imm, logic cnd, int idx);
        logic [35:0] e;
        e = expect_of(op, a, imm && op inside {[cgl_pkg::CGL_OP_GT_S : cgl_pkg::CGL_OP_GT_U],
            cgl_pkg::CGL_OP_LE_U} ? ~b : b);
        opValid = 1'b1;
        opCode = op;
        {firstSourceReg, secondSourceReg, immediateOperand} = {a, b, ~b};
        {useImmediate, destIsCondition, generalDestIdx, conditionDestIdx} = {imm, cnd, 6'(idx), 3'(idx)};
        @(negedge clk_sys);
        if (cnd)
        begin
            `CHK({condWriteEn, gprWriteEn, condWriteIdx, condWriteData}, {2'b10, 3'(idx), e[35:32]})
            `CHK(condBranchReady[3'(idx)], 1'b0)
        end
        else
            `CHK({gprWriteEn, condWriteEn, gprWriteIdx, gprWriteData}, {2'b10, 6'(idx), e[31:0]})
    endtask : issue
    task automatic idle_check();
        opValid = 0;
        opCode = cgl_pkg::CGL_OP_GT_S;
        @(negedge clk_sys);
        `CHK({gprWriteEn, condWriteEn, condBranchReady}, 10'h0FF)
        opCode = cgl_pkg::CGL_OP_NONE;
        opValid = 1;
        @(negedge clk_sys);
        `CHK({gprWriteEn, condWriteEn}, 2'b00)
        opValid = 0;
    endtask : idle_check
    task automatic t_scalar();
        logic [31:0] av [3] = '{32'h80000000, 32'h00001234, 32'hFFFFFFFF};
        logic [31:0] bv [3] = '{32'h7FFFFFFF, 32'h00001234, 32'h00000001};
        for (int op = 1; op < 7; op++)
            if (op != 4 && op != 5)
                for (int k = 0; k < 12; k++)
                    issue(cgl_pkg::cgl_op_t'(op), av[k%3], k[3] ? ~bv[k%3] : bv[k%3], k[3], k[2], k);
        idle_check();
        $display("scalar compares done");
    endtask : t_scalar
    task automatic t_packed();
        issue(cgl_pkg::CGL_OP_GT_PH, 32'h80000001, 32'h7FFF0000, 1'b1, 1'b1, 1);
        issue(cgl_pkg::CGL_OP_GT_PH, 32'h7FFF8000, 32'h80017FFF, 1'b0, 1'b0, 2);
        issue(cgl_pkg::CGL_OP_GTU_PB, 32'hFF00807F, 32'h7F0180FF, 1'b0, 1'b1, 3);
        issue(cgl_pkg::CGL_OP_GTU_PB, 32'h01FF0080, 32'h00FE017F, 1'b1, 1'b0, 4);
        idle_check();
        $display("packed compares done");
    endtask : t_packed
    task automatic t_float();
        logic [31:0] fa [5] = '{32'h3F800000, 32'hBF800000, 32'h7FC00000, 32'h00000000, 32'hBF000000};
        logic [31:0] fb [5] = '{32'h3F000000, 32'h3F000000, 32'h00000000, 32'h80000000, 32'hBF800000};
        for (int k = 0; k < 10; k++)
            issue(cgl_pkg::CGL_OP_GT_F, fa[k%5], fb[k%5], 1'b0, k[0], k);
        idle_check();
        $display("float compares done");
    endtask : t_float
    task automatic t_branch();
        int n;
        for (int t = 0; t < 2; t++)
        begin
            issue(cgl_pkg::CGL_OP_GT_U, 32'h5, t ? 32'h9 : 32'h2, 1'b0, 1'b1, 5);
            opValid = 0;
            brReq = 1;
            brIdx = 3'h5;
            n = 0;
            while (brDone !== 1'b1 && n < 10)
            begin
                @(negedge clk_sys);
                n++;
            end
            brReq = 0;
            `CHK({n, brTrue}, {32'd2, t == 0})
            @(negedge clk_sys);
        end
        $display("branch latency done");
    endtask : t_branch
    task automatic t_reset();
        issue(cgl_pkg::CGL_OP_GT_S, 32'h00000009, 32'h00000002, 1'b0, 1'b1, 6);
        opValid = 0;
        reset_n = 0;
        @(negedge clk_sys);
        `CHK({gprWriteEn, condWriteEn, condWriteIdx, condWriteData, condBranchReady}, 17'h000FF)
        reset_n = 1;
        @(negedge clk_sys);
        `CHK({gprWriteEn, condWriteEn, gprWriteIdx, condBranchReady}, 16'h00FF)
        $display("mid-run reset done");
    endtask : t_reset
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        repeat (8) @(negedge clk_sys);
        reset_n = 1;
        @(negedge clk_sys);
        `CHK({gprWriteEn, condWriteEn, gprWriteData, condBranchReady}, 42'h000000000FF)
        t_scalar();
        t_packed();
        t_float();
        t_branch();
        t_reset();
        tally_and_finish();
    end
endmodule : compare_greater_less_unit_tb
`default_nettype wire
